//--- hdl/plsf_source_filter.sv
// Position loop feedback select, command filter and integrator input
// How it works
// - Select 0 takes main encoder feedback, select 1 the secondary one.
// - Select 2 takes the third encoder, refused when it is not fitted.
// - Other secondary modes drive a pulse or gearing output, main only.
// - Filter period takes only the listed codes and resets to off.
// - The command is smoothed by an equal-weight window of period length.
// - A zero period passes the command through unfiltered.
// - The filter serves every command source but only in position mode.
// - With the filter on, total motion arrives one period later.
// - The integrator input is clamped to the input limit magnitude.
// - The input limit is an unsigned 64-bit count.
// - The integrator output is clamped to a separate output limit.
`timescale 1ns/1ps
`default_nettype none
module plsf_source_filter #(
    parameter int POS_W = 32,
    parameter int SPH_LOG2 = 0,
    parameter bit HAS_TERTIARY = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Sample strobe of the position loop
    input wire logic sample,
    // Feedback encoders
    input wire logic signed [POS_W-1:0] main_pos,
    input wire logic signed [POS_W-1:0] secondary_pos,
    input wire logic signed [POS_W-1:0] tertiary_pos,
    // Command source
    input wire logic signed [POS_W-1:0] pos_cmd,
    input wire logic position_mode,
    // Settings
    input wire logic [1:0] position_feedback_select,
    input wire logic [2:0] secondary_feedback_mode,
    input wire logic [3:0] command_filter_period,
    input wire logic [63:0] integrator_input_limit,
    input wire logic [63:0] integrator_output_limit,
    // Accepted settings
    output logic [1:0] feedback_select_state,
    output logic [3:0] filter_period_state,
    output logic filter_active,
    // Pulse or gearing use of the secondary input
    output logic signed [POS_W-1:0] handwheel_input,
    output logic handwheel_valid,
    // Loop values
    output logic signed [POS_W-1:0] feedback_pos,
    output logic signed [POS_W-1:0] cmd_filtered,
    output logic signed [plsf_pkg::ACC_W-1:0] integ_in,
    output logic signed [plsf_pkg::ACC_W-1:0] integ_out,
    output logic integ_valid
);
    localparam int AW = plsf_pkg::ACC_W;

    logic sample_d_reg;
    logic signed [AW-1:0] err;
    logic signed [AW-1:0] clamped;
    logic signed [AW-1:0] acc_sum;

    // Symmetric clamp of a signed value to an unsigned magnitude
    function automatic logic signed [AW-1:0] sat(
        input logic signed [AW-1:0] v,
        input logic [63:0] lim
    );
        logic signed [AW-1:0] l;
        l = $signed({2'h0, lim});
        if (v > l)
            sat = l;
        else if (v < -l)
            sat = -l;
        else
            sat = v;
    endfunction

    // Settings latch; illegal codes keep the previous value
    always_ff @(posedge clk) begin
        if (!nrst) begin
            feedback_select_state <= plsf_pkg::FBSEL_RST;
            filter_period_state <= plsf_pkg::PER_RST;
        end else begin
            if (position_feedback_select == plsf_pkg::FB_MAIN ||
                position_feedback_select == plsf_pkg::FB_SEC ||
                (position_feedback_select == plsf_pkg::FB_TER &&
                 HAS_TERTIARY))
                feedback_select_state <= position_feedback_select;
            if (command_filter_period <= plsf_pkg::PER_CODE_MAX)
                filter_period_state <= command_filter_period;
        end
    end

    // Filter runs only with a period and in position mode
    assign filter_active = (filter_period_state != plsf_pkg::PER_OFF) &&
        position_mode;

    plsf_boxcar #(
        .POS_W(POS_W),
        .SPH_LOG2(SPH_LOG2)
    ) u_boxcar (
        .clk(clk),
        .nrst(nrst),
        .sample(sample),
        .cmd_in(pos_cmd),
        .period(filter_period_state),
        .active(filter_active),
        .cmd_out(cmd_filtered)
    );

    // Feedback mux and secondary pulse or gearing use
    always_ff @(posedge clk) begin
        if (!nrst) begin
            feedback_pos <= '0;
            handwheel_input <= '0;
            handwheel_valid <= 1'b0;
        end else begin
            handwheel_valid <= sample &&
                feedback_select_state == plsf_pkg::FB_MAIN &&
                secondary_feedback_mode != plsf_pkg::SEC_MODE_AB;
            if (sample) begin
                handwheel_input <= secondary_pos;
                unique case (feedback_select_state)
                    plsf_pkg::FB_MAIN: feedback_pos <= main_pos;
                    plsf_pkg::FB_SEC: feedback_pos <= secondary_pos;
                    plsf_pkg::FB_TER: feedback_pos <= tertiary_pos;
                    default: feedback_pos <= main_pos;
                endcase
            end
        end
    end

    // Clamped error and accumulator sum
    always_comb begin
        err = AW'(cmd_filtered) - AW'(feedback_pos);
        clamped = sat(err, integrator_input_limit);
        acc_sum = sat(integ_out + clamped, integrator_output_limit);
    end

    // Integrator update one cycle after the sample
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sample_d_reg <= 1'b0;
            integ_in <= '0;
            integ_out <= '0;
            integ_valid <= 1'b0;
        end else begin
            sample_d_reg <= sample;
            integ_valid <= sample_d_reg;
            if (sample_d_reg) begin
                integ_in <= clamped;
                integ_out <= acc_sum;
            end
        end
    end

    property p_in_clamp;
        @(posedge clk) disable iff (!nrst)
        integ_valid |-> integ_in <= $signed({2'h0, integrator_input_limit})
            && integ_in >= -$signed({2'h0, integrator_input_limit});
    endproperty
    a_in_clamp: assert property (p_in_clamp)
        else $error("integrator input above its limit");

    property p_out_clamp;
        @(posedge clk) disable iff (!nrst)
        integ_valid |-> integ_out <= $signed({2'h0, integrator_output_limit})
            && integ_out >= -$signed({2'h0, integrator_output_limit});
    endproperty
    a_out_clamp: assert property (p_out_clamp)
        else $error("integrator output above its limit");

    property p_accumulate;
        @(posedge clk) disable iff (!nrst)
        sample_d_reg |=> integ_out ==
            sat($past(integ_out) + integ_in, integrator_output_limit);
    endproperty
    a_accumulate: assert property (p_accumulate)
        else $error("integrator did not add the clamped input");

    property p_no_tertiary;
        @(posedge clk) disable iff (!nrst)
        !HAS_TERTIARY |-> feedback_select_state != plsf_pkg::FB_TER;
    endproperty
    a_no_tertiary: assert property (p_no_tertiary)
        else $error("third encoder selected but not fitted");

    property p_main_fb;
        @(posedge clk) disable iff (!nrst)
        (sample && feedback_select_state == plsf_pkg::FB_MAIN)
            |=> feedback_pos == $past(main_pos);
    endproperty
    a_main_fb: assert property (p_main_fb)
        else $error("main encoder not taken as feedback");

    property p_sec_fb;
        @(posedge clk) disable iff (!nrst)
        (sample && feedback_select_state == plsf_pkg::FB_SEC)
            |=> feedback_pos == $past(secondary_pos);
    endproperty
    a_sec_fb: assert property (p_sec_fb)
        else $error("secondary encoder not taken as feedback");

    property p_period_legal;
        @(posedge clk) disable iff (!nrst)
        filter_period_state <= plsf_pkg::PER_CODE_MAX;
    endproperty
    a_period_legal: assert property (p_period_legal)
        else $error("illegal filter period accepted");

    property p_handwheel;
        @(posedge clk) disable iff (!nrst)
        handwheel_valid |-> $past(feedback_select_state) == plsf_pkg::FB_MAIN
            && $past(secondary_feedback_mode) != plsf_pkg::SEC_MODE_AB;
    endproperty
    a_handwheel: assert property (p_handwheel)
        else $error("secondary pulse use while it feeds the loop");

    property p_mode_gate;
        @(posedge clk) disable iff (!nrst)
        (sample && !position_mode) |=> cmd_filtered == $past(pos_cmd);
    endproperty
    a_mode_gate: assert property (p_mode_gate)
        else $error("filter acted outside position mode");
endmodule
`default_nettype wire

//--- hdl/plsf_pkg.sv
// Shared constants for the position loop source and filter block
`default_nettype none
package plsf_pkg;
    // Feedback select codes
    localparam logic [1:0] FB_MAIN = 2'h0;
    localparam logic [1:0] FB_SEC = 2'h1;
    localparam logic [1:0] FB_TER = 2'h2;
    localparam logic [1:0] FBSEL_RST = 2'h0;
    // Secondary feedback mode: quadrature
    localparam logic [2:0] SEC_MODE_AB = 3'h0;
    // Filter period codes: 0 off, 1 = 0.5 ms, k = 2^(k-1) half ms
    localparam logic [3:0] PER_OFF = 4'h0;
    localparam logic [3:0] PER_CODE_MAX = 4'hb;
    localparam logic [3:0] PER_RST = 4'h0;
    // Half ms steps in the longest period (512 ms)
    localparam int PER_MAX_HALF_MS = 1024;
    // Offset of the integrator input limit in the parameter map
    localparam logic [11:0] INTIN_LIMIT_OFFSET = 12'h252;
    // Integrator arithmetic width
    localparam int ACC_W = 66;
endpackage
`default_nettype wire

//--- hdl/plsf_boxcar.sv
// Boxcar moving average on the position command
`timescale 1ns/1ps
`default_nettype none
module plsf_boxcar #(
    parameter int POS_W = 32,
    parameter int SPH_LOG2 = 0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Sample stream
    input wire logic sample,
    input wire logic signed [POS_W-1:0] cmd_in,
    // Control
    input wire logic [3:0] period,
    input wire logic active,
    // Result
    output logic signed [POS_W-1:0] cmd_out
);
    localparam int DEPTH = plsf_pkg::PER_MAX_HALF_MS << SPH_LOG2;
    localparam int AW = $clog2(DEPTH) + 1;
    localparam int SW = POS_W + AW;

    logic signed [POS_W-1:0] hist [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] fill_reg;
    logic signed [SW-1:0] sum_reg;
    logic [3:0] per_seen_reg;
    logic [AW-1:0] len;
    logic [AW-1:0] wr_next;
    logic signed [SW-1:0] sum_next;
    logic restart;

    // Window length in samples and running sums
    always_comb begin
        len = (period == plsf_pkg::PER_OFF) ? AW'(1) :
            AW'(1) << (SPH_LOG2 + int'(period) - 1);
        wr_next = (wr_reg + AW'(1) == len) ? '0 : wr_reg + AW'(1);
        sum_next = sum_reg + SW'(cmd_in) - SW'(hist[wr_reg[AW-2:0]]);
        restart = (period != per_seen_reg) || !active;
    end

    // History and output
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_reg <= '0;
            fill_reg <= '0;
            sum_reg <= '0;
            per_seen_reg <= plsf_pkg::PER_RST;
            cmd_out <= '0;
        end else begin
            per_seen_reg <= period;
            if (restart) begin
                // History cleared on period change or when off
                wr_reg <= '0;
                fill_reg <= '0;
                sum_reg <= '0;
                if (sample)
                    cmd_out <= cmd_in;
            end else if (sample) begin
                wr_reg <= wr_next;
                if (fill_reg < len) begin
                    fill_reg <= fill_reg + AW'(1);
                    sum_reg <= sum_reg + SW'(cmd_in);
                    cmd_out <= cmd_in;
                end else begin
                    sum_reg <= sum_next;
                    cmd_out <= POS_W'(sum_next >>>
                        (SPH_LOG2 + int'(period) - 1));
                end
            end
        end
    end

    // History memory
    always_ff @(posedge clk) begin
        if (sample && !restart)
            hist[wr_reg[AW-2:0]] <= cmd_in;
    end

    property p_pass_when_off;
        @(posedge clk) disable iff (!nrst)
        (sample && !active) |=> cmd_out == $past(cmd_in);
    endproperty
    a_pass_when_off: assert property (p_pass_when_off)
        else $error("unfiltered command not passed when filter off");

    property p_fill_bound;
        @(posedge clk) disable iff (!nrst)
        fill_reg <= len || restart;
    endproperty
    a_fill_bound: assert property (p_fill_bound)
        else $error("filter fill count beyond window length");
endmodule
`default_nettype wire

//--- verif/plsf_enc_model.sv
// Encoder and command source model for the source filter bench
`timescale 1ns/1ps
`default_nettype none
module plsf_enc_model #(
    parameter logic signed [31:0] MAIN_P = 32'sh0,
    parameter logic signed [31:0] SEC_P = -32'sh200,
    parameter logic signed [31:0] TER_P = 32'sh300
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Loop strobe and requested command
    input wire logic sample,
    input wire logic signed [31:0] cmd_set,
    // Encoder positions and command
    output logic signed [31:0] main_pos,
    output logic signed [31:0] secondary_pos,
    output logic signed [31:0] tertiary_pos,
    output var logic signed [31:0] pos_cmd
);
    // Motor at rest, so each encoder holds its count
    assign main_pos = MAIN_P;
    assign secondary_pos = SEC_P;
    assign tertiary_pos = TER_P;
    // Command moves between samples, never on a sampling edge
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pos_cmd <= 32'sh0;
        end else if (!sample) begin
            pos_cmd <= cmd_set;
        end
    end
endmodule
`default_nettype wire

//--- verif/position_loop_source_filter_tb_top.sv
// Self-checking bench for the position loop source and filter
`timescale 1ns/1ps
`default_nettype none
module position_loop_source_filter_tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic sample = 1'b0;
    logic pmode = 1'b1;
    logic [1:0] fsel = 2'h0;
    logic [2:0] smode = 3'h0;
    logic [3:0] per = 4'h0;
    logic [63:0] inlim = 64'h0;
    logic [63:0] outlim = 64'h0;
    logic signed [31:0] cmd_set = 32'sh0;
    logic signed [31:0] mpos, spos, tpos, pcmd, hw_in, fb_pos, cmd_f;
    logic [1:0] fb_state;
    logic [3:0] per_state;
    logic f_act, hw_valid, i_valid, hv_s, iv_s;
    logic signed [65:0] i_in, i_out, ii_s, io_s;
    logic signed [31:0] fb_s, cf_s;
    logic [1:0] sels [3] = '{2'h1, 2'h0, 2'h2};
    logic signed [31:0] fbx [3] = '{-32'sh200, 32'sh0, 32'sh300};
    logic [3:0] pcodes [3] = '{4'hb, 4'hc, 4'h2};
    logic [3:0] pexp [3] = '{4'hb, 4'hb, 4'h2};
    int ein [4] = '{10, 10, 10, -10};
    int eout [4] = '{10, 20, 25, 15};
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;

    // Far side: encoders and command source
    plsf_enc_model enc (.clk(clk), .nrst(nrst), .sample(sample),
        .cmd_set(cmd_set), .main_pos(mpos), .secondary_pos(spos),
        .tertiary_pos(tpos), .pos_cmd(pcmd));

    plsf_source_filter #(.POS_W(32), .SPH_LOG2(0), .HAS_TERTIARY(1'b1)) dut (
        .clk(clk), .nrst(nrst), .sample(sample), .main_pos(mpos),
        .secondary_pos(spos), .tertiary_pos(tpos), .pos_cmd(pcmd),
        .position_mode(pmode), .position_feedback_select(fsel),
        .secondary_feedback_mode(smode), .command_filter_period(per),
        .integrator_input_limit(inlim), .integrator_output_limit(outlim),
        .feedback_select_state(fb_state), .filter_period_state(per_state),
        .filter_active(f_act), .handwheel_input(hw_in),
        .handwheel_valid(hw_valid), .feedback_pos(fb_pos),
        .cmd_filtered(cmd_f), .integ_in(i_in), .integ_out(i_out),
        .integ_valid(i_valid));

    // Clock and hang guard
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        if (mismatches == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [65:0] seen, input logic [65:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Settings applied together, then two edges to be accepted
    task automatic setcfg(input logic [1:0] s, input logic [2:0] m,
                          input logic [3:0] p, input logic pm);
        @(posedge clk);
        fsel <= s;
        smode <= m;
        per <= p;
        pmode <= pm;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // One loop sample, capturing both answer cycles
    task automatic do_sample(input logic signed [31:0] c);
        @(posedge clk);
        cmd_set <= c;
        @(posedge clk);
        sample <= 1'b1;
        @(posedge clk);
        sample <= 1'b0;
        #1;
        fb_s = fb_pos;
        cf_s = cmd_f;
        hv_s = hw_valid;
        @(posedge clk);
        #1;
        ii_s = i_in;
        io_s = i_out;
        iv_s = i_valid;
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        check(fb_state, plsf_pkg::FBSEL_RST);
        check(per_state, plsf_pkg::PER_RST);
        check(f_act, 1'b0);
        for (int i = 0; i < 3; i++) begin
            setcfg(sels[i], plsf_pkg::SEC_MODE_AB, 4'h0, 1'b1);
            do_sample(32'sh10);
            check(fb_state, sels[i]);
            check(fb_s, fbx[i]);
            check(hv_s, 1'b0);
        end
        setcfg(2'h3, 3'h0, 4'h0, 1'b1);
        check(fb_state, 2'h2);
        setcfg(2'h0, 3'h1, 4'h0, 1'b1);
        do_sample(32'sh10);
        check(hv_s, 1'b1);
        check(hw_in, -32'sh200);
        check(hw_valid, 1'b0);
        for (int i = 0; i < 3; i++) begin
            setcfg(2'h0, 3'h0, pcodes[i], 1'b1);
            check(per_state, pexp[i]);
        end
        check(f_act, 1'b1);
        repeat (3) do_sample(32'sh0);
        do_sample(32'sh64);
        check(cf_s, 32'sh32);
        do_sample(32'sh64);
        check(cf_s, 32'sh64);
        setcfg(2'h0, 3'h0, 4'h3, 1'b1);
        repeat (5) do_sample(32'sh0);
        check(cf_s, 32'sh0);
        setcfg(2'h0, 3'h0, 4'h2, 1'b0);
        check(f_act, 1'b0);
        do_sample(-32'sh7);
        check(cf_s, -32'sh7);
        setcfg(2'h0, 3'h0, 4'h0, 1'b1);
        do_sample(32'sh21);
        check(cf_s, 32'sh21);
        @(posedge clk);
        inlim <= 64'ha;
        outlim <= 64'h19;
        for (int i = 0; i < 4; i++) begin
            do_sample(ein[i] > 0 ? 32'sh3e8 : -32'sh3e8);
            check(ii_s, ein[i]);
            check(io_s, eout[i]);
            check(iv_s, 1'b1);
        end
        @(posedge clk);
        nrst <= 1'b0;
        #1;
        check(i_valid, 1'b0);
        @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        check(i_out, 66'h0);
        check(hw_in, 32'sh0);
        report_and_stop();
    end
endmodule
`default_nettype wire
